// ==== eaw_defines.svh ====
/*
 * register map, reset values and field layout of the external-area
 * access/wait configuration bank; assumes a 32-bit APB with byte addresses.
 */
`ifndef EAW_DEFINES_SVH
`define EAW_DEFINES_SVH

`define EAW_ADDR_W        8
`define EAW_OFF_AST       8'h00
`define EAW_OFF_WCR_HI    8'h04
`define EAW_OFF_WCR_LO    8'h08
`define EAW_RST_AST       8'hFF
`define EAW_RST_WCR_HI    8'hFF
`define EAW_RST_WCR_LO    8'hFF
`define EAW_WFIELD_W      2
`define EAW_NO_WAIT       2'h0
`define EAW_AREA0         3'h0

`endif

// ==== eaw_pkg.sv ====
/*
 * types of the external-area access/wait configuration bank;
 * assumes eaw_defines.svh is on the include path.
 */
`include "eaw_defines.svh"

package eaw_pkg;

    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_T1   = 5'h02,
        PH_T2   = 5'h04,
        PH_TW   = 5'h08,
        PH_T3   = 5'h10
    } eaw_phase_t;

    typedef enum logic [1:0] {
        SEL_NONE   = 2'h0,
        SEL_AST    = 2'h1,
        SEL_WCR_HI = 2'h2,
        SEL_WCR_LO = 2'h3
    } eaw_sel_t;

    typedef struct packed {
        logic [7:0]  area_three_state_bits;
        logic [7:0]  wait_count_upper_areas;
        logic [7:0]  wait_count_lower_areas;
        logic [31:0] rdata;
        logic        hws_s1;
        logic        hws_s2;
        logic        mrst_s1;
        logic        mrst_s2;
        logic        adv_s1;
        logic        adv_s2;
        eaw_phase_t  phase;
        logic [2:0]  area;
        logic        ext;
        logic        three;
        logic [1:0]  nwait;
        logic [1:0]  wcnt;
    } eaw_state_t;

endpackage

// ==== eaw_wait_cfg.sv ====
/*
 * access-state and program-wait configuration for eight external areas,
 * with an APB register slave and a bus-cycle state sequencer.
 * assumes: ACC_* and SW_STANDBY come from logic on REF_CLK; HW_STANDBY,
 * MANUAL_RESET and ADV_MODE are pins; RST_N is the power-on reset.
 */
// Operation
// [RL1] area bit clear gives 2-state access, set gives 3-state; bit n is area n
// [RL2] same area bit enables or disables wait insertion for that area
// [RL3] on-chip memory and internal I/O ignore area bits, fixed states
// [RL4] normal mode: only the area 0 bit selects 2 or 3 states
// [RL5] access-state register loads ones on power-on and hardware standby only
// [RL6] two-bit wait field gives 0, 1, 2 or 3 program waits
// [RL7] program waits apply only when the area is 3-state
// [RL8] upper register holds areas 7..4, lower areas 3..0, high pair first
// [RL9] no program waits on on-chip memory or internal I/O
// [RL10] normal mode: only the area 0 wait field counts
// [RL11] wait registers load ones on power-on and hardware standby only
// [RL12] external device may stretch 3-state cycles with its wait request; the sequencer has no wait request input and only drives ACC_WAIT_EN
// [RL13] each state is one clock; program waits sit between T2 and T3
`timescale 1ns/1ps
`include "eaw_defines.svh"

module eaw_wait_cfg (
    input  wire logic                      REF_CLK,
    input  wire logic                      RST_N,
    input  wire logic                      HW_STANDBY,
    input  wire logic                      MANUAL_RESET,
    input  wire logic                      SW_STANDBY,
    input  wire logic                      ADV_MODE,
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [`EAW_ADDR_W-1:0]    PADDR,
    input  wire logic [31:0]               PWDATA,
    input  wire logic [3:0]                PSTRB,
    output logic      [31:0]               PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    input  wire logic                      ACC_REQ,
    input  wire logic [2:0]                ACC_AREA,
    input  wire logic                      ACC_EXT,
    output logic                           ACC_ACCEPT,
    output logic                           ACC_BUSY,
    output logic                           ACC_IN_WAIT,
    output logic                           ACC_DONE,
    output logic                           ACC_THREE,
    output logic                           ACC_WAIT_EN,
    output logic      [1:0]                ACC_NWAIT
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic eaw_pkg::eaw_sel_t reg_decode(
        input logic [`EAW_ADDR_W-1:0] addr
    );
        case (addr)
            `EAW_OFF_AST:    reg_decode = eaw_pkg::SEL_AST;
            `EAW_OFF_WCR_HI: reg_decode = eaw_pkg::SEL_WCR_HI;
            `EAW_OFF_WCR_LO: reg_decode = eaw_pkg::SEL_WCR_LO;
            default:         reg_decode = eaw_pkg::SEL_NONE;
        endcase
    endfunction

    // areas 7..4 in the upper register, 3..0 in the lower, pair 7:6 first
    function automatic logic [1:0] area_field(
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic [2:0] area
    );
        logic [7:0] r;
        r = area[2] ? hi : lo; // RL8
        case (area[1:0])
            2'h3:    area_field = r[7:6];
            2'h2:    area_field = r[5:4];
            2'h1:    area_field = r[3:2];
            default: area_field = r[1:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam eaw_pkg::eaw_state_t RST_VAL = '{
        area_three_state_bits:  `EAW_RST_AST,
        wait_count_upper_areas: `EAW_RST_WCR_HI,
        wait_count_lower_areas: `EAW_RST_WCR_LO,
        rdata:                  32'h0000_0000,
        hws_s1:                 1'b0,
        hws_s2:                 1'b0,
        mrst_s1:                1'b0,
        mrst_s2:                1'b0,
        adv_s1:                 1'b0,
        adv_s2:                 1'b0,
        phase:                  eaw_pkg::PH_IDLE,
        area:                   3'h0,
        ext:                    1'b0,
        three:                  1'b0,
        nwait:                  2'h0,
        wcnt:                   2'h0
    };

    eaw_pkg::eaw_state_t q;
    eaw_pkg::eaw_state_t d;
    eaw_pkg::eaw_sel_t   sel;
    logic                apb_setup;
    logic                apb_access;
    logic [2:0]          eff_area;
    logic                acc_three;
    logic [1:0]          acc_nwait;
    logic                accept;

    assign sel        = reg_decode(PADDR);
    assign apb_setup  = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE;

    // normal mode sees only area 0
    assign eff_area  = q.adv_s2 ? ACC_AREA : `EAW_AREA0; // RL4 RL10
    // internal space never takes 3 states or program waits
    assign acc_three = ACC_EXT && q.area_three_state_bits[eff_area]; // RL1 RL3
    assign acc_nwait = acc_three ? area_field(q.wait_count_upper_areas,
                                              q.wait_count_lower_areas,
                                              eff_area)
                                 : `EAW_NO_WAIT; // RL6 RL7 RL9
    // no new cycle while standing by or held in manual reset
    assign accept = (q.phase == eaw_pkg::PH_IDLE) && ACC_REQ && !SW_STANDBY
                    && !q.mrst_s2 && !q.hws_s2;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.hws_s1  = HW_STANDBY;
        d.hws_s2  = q.hws_s1;
        d.mrst_s1 = MANUAL_RESET;
        d.mrst_s2 = q.mrst_s1;
        d.adv_s1  = ADV_MODE;
        d.adv_s2  = q.adv_s1;

        // read data captured in setup so it comes from a flop in access
        if (apb_setup) begin
            case (sel)
                eaw_pkg::SEL_AST:    d.rdata = {24'h000000, q.area_three_state_bits};
                eaw_pkg::SEL_WCR_HI: d.rdata = {24'h000000, q.wait_count_upper_areas};
                eaw_pkg::SEL_WCR_LO: d.rdata = {24'h000000, q.wait_count_lower_areas};
                default:             d.rdata = 32'h0000_0000;
            endcase
        end

        if (apb_access && PWRITE && PSTRB[0]) begin
            case (sel)
                eaw_pkg::SEL_AST:    d.area_three_state_bits  = PWDATA[7:0];
                eaw_pkg::SEL_WCR_HI: d.wait_count_upper_areas = PWDATA[7:0];
                eaw_pkg::SEL_WCR_LO: d.wait_count_lower_areas = PWDATA[7:0];
                default: begin
                end
            endcase
        end

        // bus-cycle sequencer, one state per clock
        case (q.phase)
            eaw_pkg::PH_IDLE: begin
                if (accept) begin
                    d.area  = eff_area;
                    d.ext   = ACC_EXT;
                    d.three = acc_three; // RL2
                    d.nwait = acc_nwait;
                    d.phase = eaw_pkg::PH_T1;
                end
            end
            eaw_pkg::PH_T1: begin
                d.phase = eaw_pkg::PH_T2;
            end
            eaw_pkg::PH_T2: begin
                if (!q.three) begin
                    d.phase = eaw_pkg::PH_IDLE; // RL1 RL3
                end else if (q.nwait != `EAW_NO_WAIT) begin
                    d.wcnt  = q.nwait; // RL13
                    d.phase = eaw_pkg::PH_TW;
                end else begin
                    d.phase = eaw_pkg::PH_T3;
                end
            end
            eaw_pkg::PH_TW: begin
                d.wcnt = q.wcnt - 2'h1; // RL13
                if (q.wcnt == 2'h1) begin
                    d.phase = eaw_pkg::PH_T3;
                end
            end
            eaw_pkg::PH_T3: begin
                d.phase = eaw_pkg::PH_IDLE;
            end
            default: begin
                d.phase = eaw_pkg::PH_IDLE;
            end
        endcase

        // manual reset aborts the cycle but keeps the configuration
        if (q.mrst_s2) begin
            d.phase = eaw_pkg::PH_IDLE; // RL5 RL11
        end
        // hardware standby reloads defaults and wins over a write
        if (q.hws_s2) begin
            d.area_three_state_bits  = `EAW_RST_AST; // RL5
            d.wait_count_upper_areas = `EAW_RST_WCR_HI; // RL11
            d.wait_count_lower_areas = `EAW_RST_WCR_LO; // RL11
            d.phase                  = eaw_pkg::PH_IDLE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            q <= RST_VAL; // RL5 RL11
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign PRDATA      = q.rdata;
    assign PREADY      = 1'b1;
    assign PSLVERR     = apb_access && (sel == eaw_pkg::SEL_NONE);
    assign ACC_ACCEPT  = accept;
    assign ACC_BUSY    = (q.phase != eaw_pkg::PH_IDLE);
    assign ACC_IN_WAIT = (q.phase == eaw_pkg::PH_TW);
    assign ACC_DONE    = ((q.phase == eaw_pkg::PH_T2) && !q.three)
                         || (q.phase == eaw_pkg::PH_T3);
    assign ACC_THREE   = q.three;
    // wait enable follows the 3-state flag of the last accepted cycle and holds it while idle; no external wait request comes in
    assign ACC_WAIT_EN = q.three; // RL2
    assign ACC_NWAIT   = q.nwait;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    a_por_ast_ones: assert property ( // RL5
        disable iff (1'b0) !RST_N |=> q.area_three_state_bits == 8'hFF)
        else $error("access-state register not all ones after power-on");

    a_mrst_keeps: assert property ( // RL5
        q.mrst_s2 && !q.hws_s2 && !apb_access |=> $stable(q.area_three_state_bits))
        else $error("manual reset disturbed access-state register");

    a_hws_wait_ones: assert property ( // RL11
        q.hws_s2 |=> q.wait_count_upper_areas == 8'hFF
                     && q.wait_count_lower_areas == 8'hFF)
        else $error("wait registers not reloaded in hardware standby");

    a_two_state_len: assert property ( // RL1
        accept && ACC_EXT && !acc_three |-> ##2 ACC_DONE)
        else $error("2-state access did not end after two states");

    a_internal_fixed: assert property ( // RL3
        accept && !ACC_EXT |-> ##2 (ACC_DONE && !ACC_THREE && ACC_NWAIT == 2'h0))
        else $error("internal access took external timing");

    a_three_wait_len: assert property ( // RL6
        accept && acc_three && acc_nwait == 2'h3 |-> ##3 ACC_IN_WAIT [*3] ##1 ACC_DONE)
        else $error("three program waits not placed between T2 and T3");

    a_wait_gated: assert property ( // RL7
        ACC_BUSY && !ACC_THREE |-> ACC_NWAIT == 2'h0 && !ACC_IN_WAIT)
        else $error("program wait in a 2-state cycle");

    a_no_wait_int: assert property ( // RL9
        ACC_BUSY && !q.ext |-> !ACC_IN_WAIT && !ACC_WAIT_EN)
        else $error("wait inserted on internal access");

    a_normal_area0: assert property ( // RL4
        accept && !q.adv_s2 && ACC_EXT
        |=> ACC_THREE == $past(q.area_three_state_bits[0]))
        else $error("normal mode used a bit other than area 0");

    a_normal_wait0: assert property ( // RL10
        accept && !q.adv_s2 && acc_three
        |=> ACC_NWAIT == $past(q.wait_count_lower_areas[1:0]))
        else $error("normal mode used a wait field other than area 0");

    a_upper_layout: assert property ( // RL8
        accept && q.adv_s2 && acc_three && ACC_AREA == 3'h7
        |=> ACC_NWAIT == $past(q.wait_count_upper_areas[7:6]))
        else $error("area 7 wait field not at upper bits 7:6");

    a_por_wait_ones: assert property ( // RL11
        disable iff (1'b0) !RST_N |=> q.wait_count_upper_areas == 8'hFF
                                      && q.wait_count_lower_areas == 8'hFF)
        else $error("wait registers not all ones after power-on");

    a_wait_end_t3: assert property ( // RL13
        ACC_IN_WAIT && q.wcnt == 2'h1 && !q.mrst_s2 && !q.hws_s2
        |=> ACC_DONE && !ACC_IN_WAIT)
        else $error("program waits not followed by the final state");

    c_three_wait: cover property (accept && acc_three && acc_nwait == 2'h3);
    c_two_state: cover property (accept && ACC_EXT && !acc_three);
    c_hws_reload: cover property (q.hws_s2 && ACC_BUSY);
    c_apb_write: cover property (apb_access && PWRITE && sel == eaw_pkg::SEL_AST);
    c_normal_mode: cover property (accept && !q.adv_s2 && acc_three);

endmodule

// ==== eaw_ext_dev.sv ====
/*
 * model of the external device on the far side of the bus cycle;
 * assumes the cycle outputs of eaw_wait_cfg on the same clock.
 */
`timescale 1ns/1ps

module eaw_ext_dev (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic       in_wait,
    input  wire logic       done,
    input  wire logic       wait_en,
    input  wire logic       slow,
    output logic      [3:0] waits_seen,
    output logic            stretch_req
);
    logic [3:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // waits are counted only until the final state shows
    always_ff @(posedge clk) begin
        if (!busy) begin
            cnt_q <= 4'h0;
        end else if (in_wait) begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (done) begin
            waits_seen <= cnt_q;
        end
    end

    // a slow device may stretch only where wait insertion is enabled
    assign stretch_req = slow & wait_en;
endmodule

// ==== testbench.sv ====
/*
 * self-checking bench of eaw_wait_cfg with an external device model;
 * assumes eaw_defines.svh on the include path.
 */
`timescale 1ns/1ps
`include "eaw_defines.svh"

module testbench;
    typedef struct packed {
        logic [7:0] ast;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [2:0] area;
        logic       ext;
        logic [1:0] n;
    } eaw_row_t;

    logic        clk = 1'b0;
    logic        rst_n, hws, mrst, sws, adv, psel, pen, pwr, req, ext;
    logic        pready, pslverr, accept, busy, inw, done, three, wen, strq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, waits_seen;
    logic [2:0]  area;
    logic [1:0]  nwait;
    int          mismatches = 0;
    int          n_tests = 0;
    eaw_row_t    rows [12] = '{
        '{8'hFF, 8'hFF, 8'hE4, 3'h0, 1'b1, 2'h0}, '{8'hFF, 8'hFF, 8'hE4, 3'h1, 1'b1, 2'h1},
        '{8'hFF, 8'hFF, 8'hE4, 3'h2, 1'b1, 2'h2}, '{8'hFF, 8'hFF, 8'hE4, 3'h3, 1'b1, 2'h3},
        '{8'hFF, 8'h1B, 8'hFF, 3'h4, 1'b1, 2'h3}, '{8'hFF, 8'h1B, 8'hFF, 3'h5, 1'b1, 2'h2},
        '{8'hFF, 8'h1B, 8'hFF, 3'h6, 1'b1, 2'h1}, '{8'hFF, 8'h1B, 8'hFF, 3'h7, 1'b1, 2'h0},
        '{8'h7F, 8'hFF, 8'hFF, 3'h7, 1'b1, 2'h0}, '{8'hFF, 8'hFF, 8'hFF, 3'h4, 1'b0, 2'h0},
        '{8'hFE, 8'hFF, 8'hFF, 3'h0, 1'b1, 2'h0}, '{8'hFD, 8'hFF, 8'hFF, 3'h1, 1'b1, 2'h0}};

    always #4 clk = ~clk;

    eaw_wait_cfg eaw_wait_cfg_i (
        .REF_CLK(clk), .RST_N(rst_n), .HW_STANDBY(hws), .MANUAL_RESET(mrst),
        .SW_STANDBY(sws), .ADV_MODE(adv), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ACC_REQ(req), .ACC_AREA(area), .ACC_EXT(ext),
        .ACC_ACCEPT(accept), .ACC_BUSY(busy), .ACC_IN_WAIT(inw), .ACC_DONE(done),
        .ACC_THREE(three), .ACC_WAIT_EN(wen), .ACC_NWAIT(nwait));

    eaw_ext_dev eaw_ext_dev_i (
        .clk(clk), .busy(busy), .in_wait(inw), .done(done), .wait_en(wen),
        .slow(1'b1), .waits_seen(waits_seen), .stretch_req(strq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic bound(input int i);
        if (i >= 16) begin
            check("timeout", 32'h0, 32'h1);
            tally_and_finish();
        end
    endtask

    // entered just after a rising edge; one idle cycle follows each transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int i;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        bound(i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string w, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        logic        er;
        apb(1'b0, a, 32'h0, q, er);
        check(w, q, {24'h0, e});
    endtask

    task automatic run(input eaw_row_t r, input logic advm);
        logic [31:0] q;
        logic        er, th, sr;
        logic [3:0]  st;
        int          i, len;
        apb(1'b1, `EAW_OFF_AST, {24'h0, r.ast}, q, er);
        apb(1'b1, `EAW_OFF_WCR_HI, {24'h0, r.hi}, q, er);
        apb(1'b1, `EAW_OFF_WCR_LO, {24'h0, r.lo}, q, er);
        th = r.ext & r.ast[advm ? r.area : 3'h0];
        req <= 1'b1;
        area <= r.area;
        ext <= r.ext;
        // outputs looked at on the falling edge, where they have settled
        for (i = 0; i < 16; i++) begin
            @(negedge clk);
            if (accept === 1'b1) break;
        end
        bound(i);
        @(posedge clk);
        req <= 1'b0;
        for (len = 1; len < 16; len++) begin
            @(negedge clk);
            if (len == 1) st = {three, wen, nwait};
            if (len == 1) sr = strq;
            if (done === 1'b1) break;
        end
        bound(len);
        check("cycle_len", 32'(len), th ? 32'h3 + 32'(r.n) : 32'h2);
        check("state_wait", {28'h0, st}, {28'h0, th, th, r.n});
        check("stretch_req", {31'h0, sr}, {31'h0, th});
        // model stores its count at the edge that ends the final state
        @(posedge clk);
        @(negedge clk);
        check("waits_seen", {28'h0, waits_seen}, {30'h0, r.n});
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic        er;
        {rst_n, hws, mrst, sws, psel, pen, pwr, req, ext} = '0;
        adv = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        area = 3'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd("ast_reset", `EAW_OFF_AST, 8'hFF);
        rd("hi_reset", `EAW_OFF_WCR_HI, 8'hFF);
        rd("lo_reset", `EAW_OFF_WCR_LO, 8'hFF);
        $display("test reset values done");
        foreach (rows[k]) run(rows[k], 1'b1);
        $display("test row table done");
        // normal mode: the area 0 bit and field stand for every area
        adv <= 1'b0;
        repeat (3) @(posedge clk);
        run('{8'h01, 8'h00, 8'hFE, 3'h5, 1'b1, 2'h2}, 1'b0);
        run('{8'hFE, 8'hFF, 8'hFF, 3'h5, 1'b1, 2'h0}, 1'b0);
        adv <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test normal mode done");
        apb(1'b1, `EAW_OFF_AST, 32'h5A, q, er);
        apb(1'b1, `EAW_OFF_WCR_HI, 32'hA5, q, er);
        apb(1'b1, `EAW_OFF_WCR_LO, 32'h3C, q, er);
        mrst <= 1'b1;
        sws <= 1'b1;
        repeat (4) @(posedge clk);
        mrst <= 1'b0;
        sws <= 1'b0;
        repeat (4) @(posedge clk);
        rd("ast_kept", `EAW_OFF_AST, 8'h5A);
        rd("hi_kept", `EAW_OFF_WCR_HI, 8'hA5);
        rd("lo_kept", `EAW_OFF_WCR_LO, 8'h3C);
        $display("test manual reset done");
        hws <= 1'b1;
        repeat (4) @(posedge clk);
        hws <= 1'b0;
        repeat (4) @(posedge clk);
        rd("ast_hws", `EAW_OFF_AST, 8'hFF);
        rd("hi_hws", `EAW_OFF_WCR_HI, 8'hFF);
        rd("lo_hws", `EAW_OFF_WCR_LO, 8'hFF);
        $display("test hardware standby done");
        // unmapped place answers with an error and no data
        apb(1'b0, 8'h0C, 32'h0, q, er);
        check("unmapped_err", {31'h0, er}, 32'h1);
        check("unmapped_data", q, 32'h0);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
